// [hw/pmc_pkg.sv]
// constants and types for the power mode and clock select block
// ********************************
// Functional notes
// ********************************
// Functional notes
// R1: source select write switches at once if new source runs, else waits ready
// R2: sleep with idle_on_sleep 0 stops cpu and peripheral clocks
// R3: sleep with idle_on_sleep 1 gates cpu clock, peripherals stay clocked
// R4: select 00 picks primary oscillator; primary run is the reset default
// R5: select 01 requests secondary run, everything clocked from secondary
// R6: in secondary run primary is off, secondary flag set, primary flag clear
// R7: secondary entry waits for an enable plus secondary oscillator ready
// R8: secondary to primary keeps secondary clock until primary is ready
// R9: after switch to primary: secondary flag clear, primary flag set
// R10: select 1x picks internal run from internal oscillator mux
// R11: low select bit ignored whenever high select bit is set
// R12: once on internal mux, primary is shut down, primary flag clear
// R13: internal frequency field writable anytime, takes effect at once
// R14: frequency 000 with source select clear: high/medium off, low used; code keeps high/medium on while medium select is set
// R15: high/medium stable flag set after settling, clocking continues meanwhile
// R16: already stable internal output keeps its stable flag on entry
// R17: internal to primary waits primary ready, then clears internal flags
// R18: low internal oscillator runs on if watchdog or clock-fail monitor on
// R19: frequency 000 picks low unless source select set, then medium/high
// R20: 001/010 medium if medium select else high; 011-111 always high
// R21: start-up timer counts 1024 primary periods, pll adds about 2 ms
// R22: changeover to a ready clock completes within a few periods
// R23: idle_on_sleep at bit 7, clock source select at bits 1:0
// R24: primary flag 0 means not running from the primary oscillator
// R25: clock changeover never shortens a device clock phase
package pmc_pkg;
   // ********************************
   // register map
   // ********************************
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_CTRL2 = 4'h4;
   localparam logic [3:0] OFF_CTRL3 = 4'h8;
   localparam int CTRL_IOS_BIT = 7;
   localparam int CTRL_IFS_LSB = 4;
   localparam int CTRL_PRDY_BIT = 3;
   localparam int CTRL_HFS_BIT = 2;
   localparam int CTRL_CCS_LSB = 0;
   localparam int CTRL2_SRUN_BIT = 6;
   localparam int CTRL2_MFSEL_BIT = 4;
   localparam int CTRL2_SREQ_BIT = 3;
   localparam int CTRL2_MFS_BIT = 1;
   localparam int CTRL2_LFS_BIT = 0;
   localparam int CTRL3_ISS_BIT = 7;
   localparam int CTRL3_PLL_BIT = 6;
   localparam logic [1:0] RST_CCS = 2'h0;
   localparam logic [2:0] RST_IFS = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ********************************
   // timing
   // ********************************
   localparam int CNT_W = 18;
   localparam int CLK_PERIOD_NS = 10;
   localparam int OST_TICKS = 1024;
   localparam int PLL_LOCK_TIME_US = 2000;
   localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INT_SETTLE_CYCLES = 16;
   // ********************************
   // state types
   // ********************************
   typedef enum logic [1:0] {
      MODE_RUN = 2'h0,
      MODE_IDLE = 2'h1,
      MODE_SLEEP = 2'h3
   } pmc_mode_e;
   typedef enum logic [1:0] {
      SRC_PRI = 2'h0,
      SRC_SEC = 2'h1,
      SRC_INT = 2'h3
   } pmc_src_e;
endpackage

// [hw/pmc_interval_timer.sv]
// interval counter used for start-up, pll lock and internal settling
`timescale 1ns/1ns
module pmc_interval_timer (
   input wire logic clk, // system clock
   input wire logic sys_rst, // synchronous reset
   input wire logic clear, // restart count
   input wire logic tick, // one count per pulse
   input wire logic [pmc_pkg::CNT_W-1:0] limit, // pulses until done
   output logic done // interval elapsed
);
   typedef struct packed {
      logic [pmc_pkg::CNT_W-1:0] count;
      logic done;
   } pmc_tmr_s;
   pmc_tmr_s q;
   pmc_tmr_s next_q;

   // count ticks until limit, hold done until cleared
   always_comb begin
      next_q = q;
      if (clear) begin
         next_q = '0;
      end else if (!q.done && tick) begin
         if (q.count == limit - 1'b1) begin
            next_q.done = 1'b1;
         end else begin
            next_q.count = q.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign done = q.done;
endmodule

// [hw/pmc_clk_gate_cell.sv]
// one glitch-free gate leg of the device clock changeover
`timescale 1ns/1ns
module pmc_clk_gate_cell (
   input wire logic clk, // system clock
   input wire logic sys_rst, // synchronous reset
   input wire logic tick, // source period pulse
   input wire logic want, // this source selected and ready
   input wire logic others_off, // every other leg fully off
   input wire logic kill, // clocks stopped, drop at once
   output logic busy, // leg not fully off
   output logic on, // leg passing ticks
   output logic tick_out // gated source pulse
);
   typedef struct packed {
      logic [1:0] stage;
   } pmc_gate_s;
   pmc_gate_s q;
   pmc_gate_s next_q;

   // enable moves only on own source periods, except kill drops it at once, so no phase is cut short
   always_comb begin
      next_q = q;
      if (kill) begin
         next_q.stage = 2'h0;
      end else if (tick) begin
         next_q.stage = {q.stage[0], want & others_off}; // R25 R22
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign busy = |q.stage;
   assign on = q.stage[1];
   assign tick_out = tick & q.stage[1];
endmodule

// [hw/pmc_power_mode_clock_select.sv]
// power mode controller with glitch-free device clock source changeover
`timescale 1ns/1ns
module pmc_power_mode_clock_select #(
   parameter int PLL_LOCK_CYCLES = pmc_pkg::PLL_LOCK_CYCLES
) (
   input wire logic clk, // system clock, 100 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [3:0] s_axi_awaddr, // write byte address
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte enables
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   output logic [1:0] s_axi_bresp, // write response code
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   input wire logic [3:0] s_axi_araddr, // read byte address
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response code
   input wire logic sleep_exec, // core executes sleep, one pulse
   input wire logic wake_event, // wake request, one pulse
   input wire logic primary_osc_clk, // primary oscillator pin
   input wire logic secondary_osc_clk, // secondary oscillator pin
   input wire logic secondary_osc_ready, // secondary oscillator ready pin
   input wire logic high_freq_osc_clk, // high internal oscillator
   input wire logic low_freq_osc_clk, // low internal oscillator
   input wire logic timer_secondary_osc_enable, // timer asks for secondary
   input wire logic watchdog_enable, // watchdog on
   input wire logic clock_fail_monitor_enable, // clock-fail monitor on
   output logic cpu_clk_en, // cpu clock pulse
   output logic periph_clk_en, // peripheral clock pulse
   output logic primary_osc_enable, // primary oscillator runs
   output logic high_freq_osc_enable, // high/medium internal output on
   output logic low_freq_osc_enable, // low internal oscillator runs
   output logic [1:0] active_source // source clocking the device
);
   typedef struct packed {
      logic [2:0] pri_s;
      logic [2:0] sec_s;
      logic [2:0] hf_s;
      logic [2:0] lf_s;
      logic [1:0] srdy_s;
      logic hf_div;
      logic idle_on_sleep;
      logic [2:0] internal_freq_select;
      logic [1:0] clock_source_select;
      logic medium_freq_select;
      logic secondary_osc_request;
      logic internal_source_select;
      logic pll_enable;
      pmc_pkg::pmc_src_e sel;
      pmc_pkg::pmc_src_e act;
      pmc_pkg::pmc_mode_e mode;
      logic aw_held;
      logic [3:0] awaddr;
      logic w_held;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic cpu_en;
      logic periph_en;
   } pmc_state_s;
   pmc_state_s q;
   pmc_state_s next_q;

   logic pri_tick;
   logic sec_tick;
   logic hf_tick;
   logic lf_tick;
   logic mf_tick;
   logic int_tick;
   logic sleeping;
   logic sel_low;
   logic sel_med;
   logic int_out_en;
   logic lf_en;
   logic ost_done;
   logic pll_done;
   logic settled;
   logic pri_ready;
   logic sec_ready;
   logic int_ready;
   logic tgt_ready;
   pmc_pkg::pmc_src_e target;
   logic pri_busy;
   logic sec_busy;
   logic int_busy;
   logic pri_on;
   logic sec_on;
   logic int_on;
   logic pri_gt;
   logic sec_gt;
   logic int_gt;
   logic dev_tick;
   logic pri_flag;
   logic sec_flag;
   logic hf_flag;
   logic mf_flag;
   logic lf_flag;
   logic [7:0] rd_mux;
   logic rd_hit;
   logic wr_hit;

   // ********************************
   // source pulses and selection
   // ********************************
   // edges are taken after the second sync stage only
   assign pri_tick = q.pri_s[1] & ~q.pri_s[2];
   assign sec_tick = q.sec_s[1] & ~q.sec_s[2];
   assign hf_tick = q.hf_s[1] & ~q.hf_s[2];
   assign lf_tick = q.lf_s[1] & ~q.lf_s[2];
   assign mf_tick = hf_tick & q.hf_div;
   assign sleeping = (q.mode == pmc_pkg::MODE_SLEEP);

   // internal mux choice follows the frequency field at once
   assign sel_low = (q.internal_freq_select == 3'h0) & ~q.internal_source_select; // R19 R14
   assign sel_med = ~sel_low & q.medium_freq_select & (q.internal_freq_select <= 3'h2); // R20
   assign int_tick = sel_low ? lf_tick : (sel_med ? mf_tick : hf_tick); // R13

   // high bit wins, low bit only matters when high bit is clear
   always_comb begin
      if (q.clock_source_select[1]) begin
         target = pmc_pkg::SRC_INT; // R10 R11
      end else if (q.clock_source_select[0]) begin
         target = pmc_pkg::SRC_SEC; // R5
      end else begin
         target = pmc_pkg::SRC_PRI; // R4
      end
   end

   // ********************************
   // oscillator enables and readiness
   // ********************************
   // primary stays up while starting for, or still draining, its leg
   assign primary_osc_enable = ~sleeping &
      (target == pmc_pkg::SRC_PRI | q.sel == pmc_pkg::SRC_PRI | pri_busy); // R6 R8 R12 R2
   assign int_out_en = ~sleeping & ((q.internal_freq_select != 3'h0) |
      q.internal_source_select | q.medium_freq_select); // R14 R15
   assign high_freq_osc_enable = int_out_en;
   // watchdog and fail monitor keep the low oscillator alive
   assign lf_en = (~sleeping & sel_low & (target == pmc_pkg::SRC_INT |
      q.sel == pmc_pkg::SRC_INT | int_busy)) | watchdog_enable |
      clock_fail_monitor_enable; // R18
   assign low_freq_osc_enable = lf_en;

   // start-up timer counts primary periods after enable
   pmc_interval_timer u_ost (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(~primary_osc_enable),
      .tick(pri_tick),
      .limit(pmc_pkg::CNT_W'(pmc_pkg::OST_TICKS)), // R21
      .done(ost_done)
   );

   // pll lock wait follows the start-up timer when the pll is used
   pmc_interval_timer u_pll (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(~ost_done | ~q.pll_enable),
      .tick(1'b1),
      .limit(pmc_pkg::CNT_W'(PLL_LOCK_CYCLES)), // R21
      .done(pll_done)
   );

   // internal output settling after it is turned on
   pmc_interval_timer u_settle (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(~int_out_en),
      .tick(1'b1),
      .limit(pmc_pkg::CNT_W'(pmc_pkg::INT_SETTLE_CYCLES)),
      .done(settled)
   );

   assign pri_ready = ost_done & (~q.pll_enable | pll_done); // R21
   assign sec_ready = q.srdy_s[1] &
      (q.secondary_osc_request | timer_secondary_osc_enable); // R7
   assign int_ready = sel_low ? lf_en : settled;

   always_comb begin
      unique case (target)
         pmc_pkg::SRC_PRI: tgt_ready = pri_ready;
         pmc_pkg::SRC_SEC: tgt_ready = sec_ready;
         default: tgt_ready = int_ready;
      endcase
   end

   // ********************************
   // glitch-free changeover legs
   // ********************************
   // each leg rises only after every other leg has fully dropped
   pmc_clk_gate_cell u_gate_pri (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(pri_tick),
      .want(q.sel == pmc_pkg::SRC_PRI & pri_ready),
      .others_off(~sec_busy & ~int_busy),
      .kill(sleeping),
      .busy(pri_busy),
      .on(pri_on),
      .tick_out(pri_gt)
   );

   pmc_clk_gate_cell u_gate_sec (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(sec_tick),
      .want(q.sel == pmc_pkg::SRC_SEC & sec_ready),
      .others_off(~pri_busy & ~int_busy),
      .kill(sleeping),
      .busy(sec_busy),
      .on(sec_on),
      .tick_out(sec_gt)
   );

   pmc_clk_gate_cell u_gate_int (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(int_tick),
      .want(q.sel == pmc_pkg::SRC_INT & (int_ready | int_busy)), // R15
      .others_off(~pri_busy & ~sec_busy),
      .kill(sleeping),
      .busy(int_busy),
      .on(int_on),
      .tick_out(int_gt)
   );

   assign dev_tick = pri_gt | sec_gt | int_gt; // R25

   // ********************************
   // status flags
   // ********************************
   assign pri_flag = ~sleeping & (q.act == pmc_pkg::SRC_PRI) & pri_ready; // R9 R24 R12
   assign sec_flag = ~sleeping & (q.act == pmc_pkg::SRC_SEC); // R6 R9
   // internal flags drop once the primary has taken over
   assign hf_flag = int_out_en & settled & ~sel_med & ~sel_low &
      (q.act != pmc_pkg::SRC_PRI); // R15 R16 R17
   assign mf_flag = int_out_en & settled & sel_med &
      (q.act != pmc_pkg::SRC_PRI); // R15 R16 R17
   assign lf_flag = ~sleeping & sel_low & lf_en &
      (q.act != pmc_pkg::SRC_PRI); // R19

   // ********************************
   // register bus
   // ********************************
   assign s_axi_awready = ~q.aw_held & ~q.bvalid;
   assign s_axi_wready = ~q.w_held & ~q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = ~q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = {24'h000000, q.rdata};
   assign s_axi_rresp = q.rresp;
   assign wr_hit = (q.awaddr == pmc_pkg::OFF_CTRL) | (q.awaddr == pmc_pkg::OFF_CTRL2) |
      (q.awaddr == pmc_pkg::OFF_CTRL3);

   // read data view, reserved bits are zero
   always_comb begin
      rd_mux = 8'h00;
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         pmc_pkg::OFF_CTRL: begin
            rd_mux[pmc_pkg::CTRL_IOS_BIT] = q.idle_on_sleep; // R23
            rd_mux[pmc_pkg::CTRL_IFS_LSB +: 3] = q.internal_freq_select;
            rd_mux[pmc_pkg::CTRL_PRDY_BIT] = pri_flag;
            rd_mux[pmc_pkg::CTRL_HFS_BIT] = hf_flag;
            rd_mux[pmc_pkg::CTRL_CCS_LSB +: 2] = q.clock_source_select; // R23
         end
         pmc_pkg::OFF_CTRL2: begin
            rd_mux[pmc_pkg::CTRL2_SRUN_BIT] = sec_flag;
            rd_mux[pmc_pkg::CTRL2_MFSEL_BIT] = q.medium_freq_select;
            rd_mux[pmc_pkg::CTRL2_SREQ_BIT] = q.secondary_osc_request;
            rd_mux[pmc_pkg::CTRL2_MFS_BIT] = mf_flag;
            rd_mux[pmc_pkg::CTRL2_LFS_BIT] = lf_flag;
         end
         pmc_pkg::OFF_CTRL3: begin
            rd_mux[pmc_pkg::CTRL3_ISS_BIT] = q.internal_source_select;
            rd_mux[pmc_pkg::CTRL3_PLL_BIT] = q.pll_enable;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // ********************************
   // next state
   // ********************************
   always_comb begin
      next_q = q;
      // pin synchronisers, third stage only feeds edge detection
      next_q.pri_s = {q.pri_s[1:0], primary_osc_clk};
      next_q.sec_s = {q.sec_s[1:0], secondary_osc_clk};
      next_q.hf_s = {q.hf_s[1:0], high_freq_osc_clk};
      next_q.lf_s = {q.lf_s[1:0], low_freq_osc_clk};
      next_q.srdy_s = {q.srdy_s[0], secondary_osc_ready};
      if (hf_tick) begin
         next_q.hf_div = ~q.hf_div;
      end

      // address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_q.aw_held = 1'b1;
         next_q.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_q.w_held = 1'b1;
         next_q.wdata = s_axi_wdata[7:0];
         next_q.wstrb0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready) begin
         next_q.bvalid = 1'b0;
      end
      if (q.aw_held && q.w_held && !q.bvalid) begin
         next_q.aw_held = 1'b0;
         next_q.w_held = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp = wr_hit ? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
         if (q.wstrb0 && q.awaddr == pmc_pkg::OFF_CTRL) begin
            next_q.idle_on_sleep = q.wdata[pmc_pkg::CTRL_IOS_BIT]; // R23
            next_q.internal_freq_select = q.wdata[pmc_pkg::CTRL_IFS_LSB +: 3]; // R13
            next_q.clock_source_select = q.wdata[pmc_pkg::CTRL_CCS_LSB +: 2]; // R23
         end
         if (q.wstrb0 && q.awaddr == pmc_pkg::OFF_CTRL2) begin
            next_q.medium_freq_select = q.wdata[pmc_pkg::CTRL2_MFSEL_BIT];
            next_q.secondary_osc_request = q.wdata[pmc_pkg::CTRL2_SREQ_BIT];
         end
         if (q.wstrb0 && q.awaddr == pmc_pkg::OFF_CTRL3) begin
            next_q.internal_source_select = q.wdata[pmc_pkg::CTRL3_ISS_BIT];
            next_q.pll_enable = q.wdata[pmc_pkg::CTRL3_PLL_BIT];
         end
      end

      // read answer one cycle after the address is taken
      if (q.rvalid && s_axi_rready) begin
         next_q.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_q.rvalid = 1'b1;
         next_q.rdata = rd_mux;
         next_q.rresp = rd_hit ? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
      end

      // retarget only once the new source can clock the device
      if (!sleeping && target != q.sel && tgt_ready) begin
         next_q.sel = target; // R1 R7 R8 R17
      end
      if (pri_on) begin
         next_q.act = pmc_pkg::SRC_PRI; // R9 R17
      end else if (sec_on) begin
         next_q.act = pmc_pkg::SRC_SEC; // R5
      end else if (int_on) begin
         next_q.act = pmc_pkg::SRC_INT; // R10
      end

      // sleep picks idle or full stop from the bit at that moment
      unique case (q.mode)
         pmc_pkg::MODE_RUN: begin
            if (sleep_exec) begin
               next_q.mode = q.idle_on_sleep ? pmc_pkg::MODE_IDLE : pmc_pkg::MODE_SLEEP; // R2 R3
            end
         end
         pmc_pkg::MODE_IDLE,
         pmc_pkg::MODE_SLEEP: begin
            if (wake_event) begin
               next_q.mode = pmc_pkg::MODE_RUN;
            end
         end
         default: next_q.mode = pmc_pkg::MODE_RUN;
      endcase

      // cpu gated in idle, everything gated in sleep
      next_q.cpu_en = (q.mode == pmc_pkg::MODE_RUN) & dev_tick; // R2 R3
      next_q.periph_en = (q.mode != pmc_pkg::MODE_SLEEP) & dev_tick; // R2 R3
   end

   // state register, primary run after reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
         q.clock_source_select <= pmc_pkg::RST_CCS; // R4
         q.internal_freq_select <= pmc_pkg::RST_IFS;
         q.sel <= pmc_pkg::SRC_PRI; // R4
         q.act <= pmc_pkg::SRC_PRI;
         q.mode <= pmc_pkg::MODE_RUN;
         q.bresp <= pmc_pkg::RESP_OKAY;
         q.rresp <= pmc_pkg::RESP_OKAY;
      end else begin
         q <= next_q;
      end
   end

   assign cpu_clk_en = q.cpu_en;
   assign periph_clk_en = q.periph_en;
   assign active_source = q.act;
endmodule

// [dv/pmc_props.sv]
// assertion checker for the power mode clock select block
`timescale 1ns/1ns
module pmc_props (
   input wire logic clk, // clock
   input wire logic sys_rst, // reset
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic cpu_clk_en, // cpu pulse
   input wire logic periph_clk_en, // periph pulse
   input wire logic watchdog_enable, // watchdog on
   input wire logic low_freq_osc_enable, // low osc on
   input wire logic [1:0] active_source // source
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // a pending response blocks new writes
   a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_rdata_clean: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_cpu_pulse: assert property (cpu_clk_en |=> !cpu_clk_en)
      else $error("cpu pulse longer than one cycle");
   a_cpu_with_periph: assert property (cpu_clk_en |-> periph_clk_en)
      else $error("cpu clocked without peripherals");
   a_low_kept: assert property (watchdog_enable |-> low_freq_osc_enable)
      else $error("low osc stopped under watchdog");
   a_src_legal: assert property (active_source != 2'h2)
      else $error("illegal active source");
endmodule
bind pmc_power_mode_clock_select pmc_props u_props (.clk(clk), .sys_rst(sys_rst),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .watchdog_enable(watchdog_enable),
   .low_freq_osc_enable(low_freq_osc_enable), .active_source(active_source));

// [dv/tb.sv]
// self-checking bench for the power mode clock select block
`timescale 1ns/1ns
module tb;
   logic clk = 0, sys_rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic awr, wr_r, bv, arr, rv, cpu, per, pri_en, hf_en, lf_en;
   logic slp_x = 0, wake = 0, sec_rdy = 0, wdog = 1;
   logic [3:0] awa = 0, ara = 0, stb = 0, osc = 0;
   logic [31:0] wd = 0, rd_d, seed = 32'h91EB0546;
   logic [1:0] br, rr, src_o;
   logic [33:0] q[$];
   int num_errors = 0, check_count = 0, cc, pc;
   // clock and free-running oscillator pins, periods of 4, 8 and 16 cycles
   always #5 clk = ~clk;
   always @(posedge clk) osc <= osc + 4'h1;
   pmc_power_mode_clock_select #(.PLL_LOCK_CYCLES(20)) dut (.clk(clk), .sys_rst(sys_rst),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
      .s_axi_wready(wr_r), .s_axi_wdata(wd), .s_axi_wstrb(stb), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd_d),
      .s_axi_rresp(rr), .sleep_exec(slp_x), .wake_event(wake), .primary_osc_clk(osc[1]),
      .secondary_osc_clk(osc[2]), .secondary_osc_ready(sec_rdy), .high_freq_osc_clk(osc[1]),
      .low_freq_osc_clk(osc[3]), .timer_secondary_osc_enable(1'b0), .watchdog_enable(wdog),
      .clock_fail_monitor_enable(1'b0), .cpu_clk_en(cpu), .periph_clk_en(per),
      .primary_osc_enable(pri_en), .high_freq_osc_enable(hf_en), .low_freq_osc_enable(lf_en),
      .active_source(src_o));
   // ****
   // helpers
   // ****
   task automatic check(input string n, input logic [33:0] g, input logic [33:0] e);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] e);
      logic ta, tw;
      ta = 0;
      tw = 0;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      @(posedge clk);
      q.push_back({e, 32'h0});
      awv <= 1;
      awa <= a;
      wv <= 1;
      wd <= {seed[31:8], d};
      stb <= s;
      bry <= 1;
      while (!(ta && tw)) begin
         @(posedge clk);
         if (!ta && awr) begin ta = 1; awv <= 0; end
         if (!tw && wr_r) begin tw = 1; wv <= 0; end
      end
      do @(posedge clk); while (!bv);
      bry <= 0;
   endtask
   // expected read result queued before the request goes out
   task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
      @(posedge clk);
      q.push_back({e, 24'h0, d});
      arv <= 1;
      ara <= a;
      rry <= 1;
      do @(posedge clk); while (!arr);
      arv <= 0;
      do @(posedge clk); while (!rv);
      rry <= 0;
   endtask
   task automatic src(input logic [1:0] v);
      for (int i = 0; i < 9000 && src_o !== v; i++) @(posedge clk);
      check("source", src_o, v);
   endtask
   // sleep with the given control byte, count pulses, then wake
   task automatic slp(input logic [7:0] c);
      wr(4'h0, c, 4'hF, 2'h0);
      @(posedge clk) slp_x <= 1;
      @(posedge clk) slp_x <= 0;
      repeat (20) @(posedge clk);
      cc = 0;
      pc = 0;
      repeat (64) begin @(posedge clk); cc += cpu; pc += per; end
      @(posedge clk) wake <= 1;
      @(posedge clk) wake <= 0;
      repeat (60) @(posedge clk);
   endtask
   // write and read answers compared against the oldest note
   always @(posedge clk) if ((rv && rry || bv && bry) && q.size() > 0)
      check("resp", bv ? {br, 32'h0} : {rr, rd_d}, q.pop_front());
   // hang guard, well past the longest expected run
   initial begin
      #400us;
      num_errors++;
      report_and_stop;
   end
   // ****
   // scenarios
   // ****
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 0;
      rd(4'h0, 8'h00, 2'h0);
      rd(4'hC, 8'h00, 2'h2);
      check("pri_en", pri_en, 1);
      wr(4'hC, 8'h11, 4'hF, 2'h2);
      repeat (3000) @(posedge clk);
      rd(4'h0, 8'h00, 2'h0);
      repeat (1200) @(posedge clk);
      rd(4'h0, 8'h08, 2'h0);
      wr(4'h0, seed[7:0], 4'h0, 2'h0);
      wr(4'h0, 8'h01, 4'hF, 2'h0);
      repeat (100) @(posedge clk);
      check("source", src_o, 0);
      sec_rdy <= 1;
      wr(4'h4, 8'h08, 4'h1, 2'h0);
      src(2'h1);
      rd(4'h0, 8'h01, 2'h0);
      rd(4'h4, 8'h49, 2'h0);
      check("pri_en", pri_en, 0);
      wr(4'h0, 8'h00, 4'hF, 2'h0);
      repeat (1000) @(posedge clk);
      check("source", src_o, 1);
      src(2'h0);
      rd(4'h4, 8'h08, 2'h0);
      wr(4'h0, 8'h03, 4'hF, 2'h0);
      src(2'h3);
      check("pri_en", pri_en, 0);
      check("hf_en", hf_en, 0);
      rd(4'h0, 8'h03, 2'h0);
      wr(4'h0, 8'h73, 4'hF, 2'h0);
      check("hf_en", hf_en, 1);
      repeat (40) @(posedge clk);
      rd(4'h0, 8'h77, 2'h0);
      slp(8'h73);
      check("cpu", cc, 0);
      check("periph", pc, 0);
      slp(8'hF3);
      check("cpu", cc, 0);
      check("periph", pc > 0, 1);
      wr(4'h0, 8'h70, 4'hF, 2'h0);
      src(2'h0);
      rd(4'h0, 8'h78, 2'h0);
      check("lf_en", lf_en, 1);
      report_and_stop;
   end
endmodule
